// File: hw/vga_pkg.sv
// Package for the variable gain control block: register map, reset values,
// field positions and loop timing constants.
// Assumes a 40 MHz system clock standing in for the converter clock.
package vga_pkg;
  // Register addresses on the configuration port
  localparam logic [7:0] ADDR_GAIN_UPPER = 8'h03;
  localparam logic [7:0] ADDR_GAIN_LOWER = 8'h04;
  localparam logic [7:0] ADDR_ATTACK_DECAY = 8'h05;
  localparam logic [7:0] ADDR_OVL_FAST_REF = 8'h06;
  // Reset values
  localparam logic [7:0] RST_GAIN_UPPER = 8'h3f;
  localparam logic [7:0] RST_GAIN_LOWER = 8'hff;
  localparam logic [7:0] RST_ATTACK_DECAY = 8'h00;
  localparam logic [7:0] RST_OVL_FAST_REF = 8'h00;
  // Field positions
  localparam int PREAMP_ATTENUATE_BIT_BIT = 7;
  localparam int ATTACK_LSB = 4;
  localparam int DECAY_LSB = 0;
  localparam int OVL_WEIGHT_LSB = 4;
  localparam int FAST_ACQ_BIT = 3;
  localparam int REF_LSB = 0;
  // Loop pacing: one loop update per first-stage decimated sample
  localparam int DECIM1 = 20;
  localparam logic [4:0] DECIM1_LAST = 5'd19;
  // Integrator width; gain code is the top eight bits
  localparam int INTEG_W = 24;
  localparam logic [23:0] INTEG_MAX = 24'hffffff;
  localparam logic [23:0] INTEG_RST = 24'h800000;
  // Overload at highest weight removes about 6 dB, i.e. a quarter of the code span
  localparam logic [23:0] OVL_STEP_MAX = 24'h400000;
  // Target magnitudes for reference codes 1..5 (3 dB steps below clip)
  localparam logic [16:0] REF_LVL_1 = 17'h0b504;
  localparam logic [16:0] REF_LVL_2 = 17'h08000;
  localparam logic [16:0] REF_LVL_3 = 17'h05a82;
  localparam logic [16:0] REF_LVL_4 = 17'h04000;
  localparam logic [16:0] REF_LVL_5 = 17'h02d41;
  // Host update spacing in converter clocks
  localparam int MIN_GAIN_UPDATE_CLKS = 100;
  // Output report period in first-stage samples
  localparam logic [7:0] REPORT_PERIOD = 8'd60;
endpackage

// File: hw/vga_decim1.sv
// First decimation stage: complex mix by a quarter of the band, fourth
// order comb decimating by 20, then |I|+|Q| magnitude.
// Assumes 16-bit signed converter samples, one per clock.
module vga_decim1 (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Samples
  input wire logic signed [15:0] sample_i,
  // Decimated output
  output logic tick_o,
  output logic [16:0] mag_o
);
  // Quarter-rate mix uses the coarse +/-1, +/-1/2, 0 pattern of an eighth-clock
  // rotation; adequate for power estimation only.
  logic [2:0] phase;
  logic [4:0] dcnt;
  logic signed [35:0] ii [0:3];
  logic signed [35:0] qi [0:3];
  logic signed [35:0] ic [0:3];
  logic signed [35:0] qc [0:3];
  logic signed [35:0] idl [0:3];
  logic signed [35:0] qdl [0:3];
  logic signed [35:0] mix_i;
  logic signed [35:0] mix_q;
  logic signed [35:0] s_ext;
  logic [35:0] abs_i;
  logic [35:0] abs_q;
  logic [36:0] mag_sum;
  wire dump = (dcnt == vga_pkg::DECIM1_LAST);
  assign s_ext = 36'(sample_i);
  assign mix_i = (phase == 3'd0) ? s_ext : (phase == 3'd4) ? -s_ext :
                 (phase == 3'd1 || phase == 3'd7) ? (s_ext >>> 1) :
                 (phase == 3'd3 || phase == 3'd5) ? -(s_ext >>> 1) : 36'sd0;
  assign mix_q = (phase == 3'd2) ? -s_ext : (phase == 3'd6) ? s_ext :
                 (phase == 3'd1 || phase == 3'd3) ? -(s_ext >>> 1) :
                 (phase == 3'd5 || phase == 3'd7) ? (s_ext >>> 1) : 36'sd0;
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase <= 3'd0;
      dcnt <= 5'd0;
    end
    else
    begin
      phase <= phase + 3'd1;
      dcnt <= dump ? 5'd0 : dcnt + 5'd1;
    end
  end
  genvar k;
  generate
    for (k = 0; k < 4; k++)
    begin : g_stage
      always_ff @(posedge clk_sys_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          ii[k] <= 36'sd0;
          qi[k] <= 36'sd0;
          ic[k] <= 36'sd0;
          qc[k] <= 36'sd0;
          idl[k] <= 36'sd0;
          qdl[k] <= 36'sd0;
        end
        else
        begin
          ii[k] <= ii[k] + ((k == 0) ? mix_i : ii[(k == 0) ? 0 : k - 1]);
          qi[k] <= qi[k] + ((k == 0) ? mix_q : qi[(k == 0) ? 0 : k - 1]);
          if (dump)
          begin
            idl[k] <= (k == 0) ? ii[3] : ic[(k == 0) ? 0 : k - 1];
            qdl[k] <= (k == 0) ? qi[3] : qc[(k == 0) ? 0 : k - 1];
            ic[k] <= ((k == 0) ? ii[3] : ic[(k == 0) ? 0 : k - 1]) - idl[k];
            qc[k] <= ((k == 0) ? qi[3] : qc[(k == 0) ? 0 : k - 1]) - qdl[k];
          end
        end
      end
    end
  endgenerate
  assign abs_i = ic[3][35] ? 36'(-ic[3]) : 36'(ic[3]);
  assign abs_q = qc[3][35] ? 36'(-qc[3]) : 36'(qc[3]);
  assign mag_sum = {1'b0, abs_i} + {1'b0, abs_q};
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tick_o <= 1'b0;
      mag_o <= 17'd0;
    end
    else
    begin
      tick_o <= dump;
      // Comb gain 20^4 ~ 2^17.3; keep 17 bits above that
      mag_o <= (|mag_sum[36:35]) ? 17'h1ffff : mag_sum[34:18];
    end
  end
endmodule

// File: hw/vga_gain_ctrl.sv
// Variable gain control: configuration registers, manual gain word,
// automatic gain loop and gain report for the serial sample output.
// Assumes a synchronous register write/read port from the serial
// configuration logic and an overload comparator arriving asynchronously.
// Notes on behaviour
// - Upper byte bit 7 turns on fixed 16 dB preamp attenuation.
// - An 8-bit DAC code from manual word or loop sets amplifier gain.
// - Reference codes 1..5 target 3, 6, 9, 12, 15 dB below clip.
// - Reference code zero means manual mode; nonzero enables the loop.
// - Overload above clip threshold lowers gain through the integrator.
// - While overloaded, only the overload path drives the integrator.
// - Power estimate is |I|+|Q| after the decimate-by-20 stage.
// - Loop state updates once per twenty converter clocks.
// - Report overload count, reset count and gain MSBs in output data.
// - Too large signal lowers gain by error times attack scale.
// - Too small signal raises gain by error scaled by attack minus decay.
// - Attack code sets loop bandwidth in half-octave steps from minimum.
// - Decay code stretches recovery in half-octave steps up to 180:1.
// - Overload weight doubles per code; top code cuts gain 6 dB.
// - Fast-acquire bit lowers DAC source resistance eightfold.
// - Decimation path mixes by an eighth of the clock first.
// - First stage is a fourth-order comb decimating by twenty.
module vga_gain_ctrl (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Converter side
  input wire logic signed [15:0] sample_i,
  input wire logic overload_indication_i,
  input wire logic adc_reset_event_i,
  // Report configuration
  input wire logic report_enable_i,
  // Gain DAC and preamp
  output logic [7:0] gain_dac_code_o,
  output logic dac_low_res_o,
  output logic preamp_attenuate_bit_o,
  output logic auto_mode_o,
  // Report to serial sample output
  output logic report_valid_o,
  output logic [7:0] report_gain_o,
  output logic [7:0] report_overload_cnt_o,
  output logic [7:0] report_reset_cnt_o
);
  typedef enum logic [1:0] {
    VGA_SRC_MANUAL = 2'b00,
    VGA_SRC_TRACK = 2'b01,
    VGA_SRC_OVERLOAD = 2'b10
  } vga_src_t;

  logic [7:0] gain_word_upper;
  logic [7:0] gain_word_lower;
  logic [7:0] loop_attack_decay;
  logic [7:0] overload_fast_reference;
  logic [7:0] manual_code;
  logic [23:0] integ;
  logic [23:0] next_integ;
  vga_src_t src;
  vga_src_t next_src;
  logic ovl_s1;
  logic ovl_s2;
  logic rst_s1;
  logic rst_s2;
  logic rst_s3;
  logic ovl_s3;
  logic [7:0] ovl_cnt;
  logic [7:0] rst_cnt;
  logic [7:0] rep_cnt;
  logic ovl_latched;
  logic dec_tick;
  logic [16:0] mag;

  // Address decode, used by write and read paths
  function automatic logic [2:0] addr_sel(input logic [7:0] a);
    addr_sel = (a == vga_pkg::ADDR_GAIN_UPPER) ? 3'd1 :
               (a == vga_pkg::ADDR_GAIN_LOWER) ? 3'd2 :
               (a == vga_pkg::ADDR_ATTACK_DECAY) ? 3'd3 :
               (a == vga_pkg::ADDR_OVL_FAST_REF) ? 3'd4 : 3'd0;
  endfunction

  wire [2:0] wsel = addr_sel(reg_addr_i);
  wire wr_upper = reg_wr_i && (wsel == 3'd1);
  wire wr_lower = reg_wr_i && (wsel == 3'd2);
  wire wr_ad = reg_wr_i && (wsel == 3'd3);
  wire wr_ofr = reg_wr_i && (wsel == 3'd4);

  wire [3:0] attack_rate_field = loop_attack_decay[vga_pkg::ATTACK_LSB +: 4];
  wire [3:0] decay_ratio_field = loop_attack_decay[vga_pkg::DECAY_LSB +: 4];
  wire [3:0] overload_weight_field = overload_fast_reference[vga_pkg::OVL_WEIGHT_LSB +: 4];
  wire fast_acquire_bit = overload_fast_reference[vga_pkg::FAST_ACQ_BIT];
  wire [2:0] reference_level_field = overload_fast_reference[vga_pkg::REF_LSB +: 3];

  wire auto_en = (reference_level_field != 3'd0);

  wire [16:0] ref_lvl =
    (reference_level_field == 3'd1) ? vga_pkg::REF_LVL_1 :
    (reference_level_field == 3'd2) ? vga_pkg::REF_LVL_2 :
    (reference_level_field == 3'd3) ? vga_pkg::REF_LVL_3 :
    (reference_level_field == 3'd4) ? vga_pkg::REF_LVL_4 : vga_pkg::REF_LVL_5;

  vga_decim1 u_decim1 (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .sample_i(sample_i),
    .tick_o(dec_tick),
    .mag_o(mag)
  );

  // Error magnitude and direction
  wire too_big = (mag > ref_lvl);
  wire [16:0] err = too_big ? (mag - ref_lvl) : (ref_lvl - mag);

  // Attack scale, sqrt2 per code via half step
  wire [23:0] err_ext = {7'd0, err};
  wire [23:0] att_base = err_ext >> (5'd12 - {2'b00, attack_rate_field[3:1]});
  wire [23:0] att_step = attack_rate_field[0] ? (att_base + (att_base >> 1)) : att_base;
  // Recovery step shrinks by sqrt2 per decay code
  wire [23:0] dec_base = att_step >> decay_ratio_field[3:1];
  wire [23:0] rec_step = decay_ratio_field[0] ? (dec_base - (dec_base >> 2) - (dec_base >> 5))
                                              : dec_base;
  wire [23:0] ovl_step = vga_pkg::OVL_STEP_MAX >> (4'd15 - overload_weight_field);

  always_comb
  begin
    next_src = VGA_SRC_MANUAL;
    if (auto_en)
      next_src = ovl_latched ? VGA_SRC_OVERLOAD : VGA_SRC_TRACK;
  end

  always_comb
  begin
    next_integ = integ;
    unique case (next_src)
      VGA_SRC_MANUAL:
        next_integ = {manual_code, 16'h0000};
      VGA_SRC_OVERLOAD:
        next_integ = (integ > ovl_step) ? (integ - ovl_step) : 24'd0;
      VGA_SRC_TRACK:
        if (too_big)
          next_integ = (integ > att_step) ? (integ - att_step) : 24'd0;
        else
          next_integ = (vga_pkg::INTEG_MAX - integ > rec_step) ? (integ + rec_step)
                                                              : vga_pkg::INTEG_MAX;
    endcase
  end

  // Configuration registers
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gain_word_upper <= vga_pkg::RST_GAIN_UPPER;
      gain_word_lower <= vga_pkg::RST_GAIN_LOWER;
      loop_attack_decay <= vga_pkg::RST_ATTACK_DECAY;
      overload_fast_reference <= vga_pkg::RST_OVL_FAST_REF;
      manual_code <= 8'h7f;
    end
    else
    begin
      if (wr_upper)
        gain_word_upper <= reg_wdata_i;
      if (wr_lower)
        gain_word_lower <= reg_wdata_i;
      if (wr_ad)
        loop_attack_decay <= reg_wdata_i;
      if (wr_ofr)
        overload_fast_reference <= reg_wdata_i;
      if (wr_lower)
        manual_code <= {gain_word_upper[6:0], reg_wdata_i[7]};
    end
  end

  // Overload and reset event synchronisers
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ovl_s1 <= 1'b0;
      ovl_s2 <= 1'b0;
      ovl_s3 <= 1'b0;
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
      rst_s3 <= 1'b0;
    end
    else
    begin
      ovl_s1 <= overload_indication_i;
      ovl_s2 <= ovl_s1;
      ovl_s3 <= ovl_s2;
      rst_s1 <= adc_reset_event_i;
      rst_s2 <= rst_s1;
      rst_s3 <= rst_s2;
    end
  end

  // Overload seen at any time in a decimation interval counts for that
  // update; the set wins over the per-tick clear.
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ovl_latched <= 1'b0;
    else if (ovl_s2)
      ovl_latched <= 1'b1;
    else if (dec_tick)
      ovl_latched <= 1'b0;
  end

  // Loop state updates on decimated tick
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      integ <= vga_pkg::INTEG_RST;
      src <= VGA_SRC_MANUAL;
    end
    else if (dec_tick)
    begin
      integ <= next_integ;
      src <= next_src;
    end
  end

  // Event counts over one report period
  wire ovl_rise = ovl_s2 && !ovl_s3;
  wire rst_rise = rst_s2 && !rst_s3;
  wire rep_end = dec_tick && (rep_cnt == vga_pkg::REPORT_PERIOD - 8'd1);
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rep_cnt <= 8'd0;
      ovl_cnt <= 8'd0;
      rst_cnt <= 8'd0;
      report_valid_o <= 1'b0;
      report_gain_o <= 8'd0;
      report_overload_cnt_o <= 8'd0;
      report_reset_cnt_o <= 8'd0;
    end
    else
    begin
      report_valid_o <= rep_end && report_enable_i;
      if (dec_tick)
        rep_cnt <= rep_end ? 8'd0 : rep_cnt + 8'd1;
      if (rep_end)
      begin
        report_gain_o <= gain_dac_code_o;
        report_overload_cnt_o <= ovl_cnt;
        report_reset_cnt_o <= rst_cnt;
        ovl_cnt <= {7'd0, ovl_rise};
        rst_cnt <= {7'd0, rst_rise};
      end
      else
      begin
        if (ovl_rise && ovl_cnt != 8'hff)
          ovl_cnt <= ovl_cnt + 8'd1;
        if (rst_rise && rst_cnt != 8'hff)
          rst_cnt <= rst_cnt + 8'd1;
      end
    end
  end

  // Read mux
  wire [2:0] rsel = addr_sel(reg_addr_i);
  wire [7:0] rd_mux = (rsel == 3'd1) ? gain_word_upper :
                      (rsel == 3'd2) ? gain_word_lower :
                      (rsel == 3'd3) ? loop_attack_decay :
                      (rsel == 3'd4) ? overload_fast_reference : 8'h00;

  // Drive outputs from flops
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= 8'h00;
      gain_dac_code_o <= 8'h7f;
      dac_low_res_o <= 1'b0;
      preamp_attenuate_bit_o <= 1'b0;
      auto_mode_o <= 1'b0;
    end
    else
    begin
      reg_rdata_o <= rd_mux;
      gain_dac_code_o <= (src == VGA_SRC_MANUAL) ? manual_code : integ[23:16];
      dac_low_res_o <= fast_acquire_bit;
      preamp_attenuate_bit_o <= gain_word_upper[vga_pkg::PREAMP_ATTENUATE_BIT_BIT];
      auto_mode_o <= auto_en;
    end
  end
endmodule

// File: test/vga_gain_props.sv
// Checker for the gain control block, watching its ports only.
// Assumes one clock domain; attached by bind from the bench.
module vga_gain_props (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  // Converter side
  input wire logic overload_indication_i,
  input wire logic report_enable_i,
  // Outputs
  input wire logic [7:0] gain_dac_code_o,
  input wire logic dac_low_res_o,
  input wire logic preamp_attenuate_bit_o,
  input wire logic auto_mode_o,
  input wire logic report_valid_o,
  input wire logic [7:0] report_gain_o
);
  logic att_q, fast_q, ref_q, rep_seen;
  logic [3:0] wt_q;
  logic [6:0] up_q;
  logic [7:0] man_q, snap;
  logic [5:0] mode_cnt, low_cnt, ovl_run;
  logic [4:0] chg_cnt;
  logic [10:0] rep_gap;
  wire wr_up = reg_wr_i && reg_addr_i == vga_pkg::ADDR_GAIN_UPPER;
  wire wr_lo = reg_wr_i && reg_addr_i == vga_pkg::ADDR_GAIN_LOWER;
  wire wr_cfg = reg_wr_i && reg_addr_i == vga_pkg::ADDR_OVL_FAST_REF;

  // Saturating counters keep every bound a small fixed number
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      {att_q, fast_q, ref_q, rep_seen, wt_q, mode_cnt, chg_cnt, ovl_run, rep_gap} <= '0;
      up_q <= 7'h3f;
      man_q <= 8'h7f;
      snap <= 8'h00;
      low_cnt <= 6'h3f;
    end
    else
    begin
      if (wr_up) {att_q, up_q} <= reg_wdata_i;
      if (wr_lo) man_q <= {up_q, reg_wdata_i[7]};
      if (wr_cfg) {wt_q, fast_q} <= reg_wdata_i[7:3];
      if (wr_cfg) ref_q <= |reg_wdata_i[2:0];
      mode_cnt <= $changed(auto_mode_o) ? 6'h00 : mode_cnt + 6'(mode_cnt != 6'h3f);
      low_cnt <= wr_lo ? 6'h00 : low_cnt + 6'(low_cnt != 6'h3f);
      chg_cnt <= $changed(gain_dac_code_o) ? 5'h00 : chg_cnt + 5'(chg_cnt != 5'h1f);
      ovl_run <= overload_indication_i ? ovl_run + 6'(ovl_run != 6'h3f) : 6'h00;
      // Snapshot once the sync delay has passed, so a last loop raise is included
      if (overload_indication_i && ovl_run == 6'h04) snap <= gain_dac_code_o;
      rep_gap <= report_valid_o ? 11'h000 : rep_gap + 11'(rep_gap != 11'h7ff);
      rep_seen <= rep_seen | report_valid_o;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence cfg_quiet;
    !wr_cfg [*3];
  endsequence
  sequence manual_settled;
    !auto_mode_o && mode_cnt == 6'h3f;
  endsequence
  sequence auto_settled;
    auto_mode_o && mode_cnt == 6'h3f;
  endsequence

  attn_follow_a: assert property (!wr_up [*3] |-> preamp_attenuate_bit_o == att_q)
    else $error("attenuate bit differs from upper byte");
  fast_follow_a: assert property (cfg_quiet |-> dac_low_res_o == fast_q)
    else $error("fast acquire output differs from register");
  mode_follow_a: assert property (cfg_quiet |-> auto_mode_o == ref_q)
    else $error("loop mode differs from reference field");
  manual_code_a: assert property (manual_settled ##0 low_cnt == 6'd40 |-> gain_dac_code_o == man_q)
    else $error("manual code differs from gain word");
  half_word_a: assert property (manual_settled ##0 $changed(gain_dac_code_o) |-> low_cnt < 6'd40)
    else $error("manual code moved without a lower byte write");
  tick_pace_a: assert property (auto_settled ##0 $changed(gain_dac_code_o)
    |-> chg_cnt == 5'd19 || chg_cnt == 5'h1f)
    else $error("loop code changed off the twenty clock pace");
  ovl_hold_a: assert property (auto_settled ##0 ovl_run >= 6'd5
    |-> gain_dac_code_o <= $past(gain_dac_code_o))
    else $error("gain rose during overload");
  ovl_cut_a: assert property (auto_settled ##0 (wt_q == 4'hf && ovl_run == 6'd40 && snap >= 8'h40)
    |-> gain_dac_code_o <= snap - 8'h40)
    else $error("overload did not cut gain by a full step");
  rep_off_a: assert property (!report_enable_i [*2] |-> !report_valid_o)
    else $error("report while disabled");
  rep_period_a: assert property (report_valid_o && rep_seen |-> rep_gap == 11'd1199)
    else $error("report period wrong");
  rep_gain_a: assert property (report_valid_o && $stable(gain_dac_code_o)
    |-> report_gain_o == gain_dac_code_o)
    else $error("reported gain differs from code");
endmodule

// File: test/vga_host_model.sv
// Host model on the configuration port: register writes and reads.
// Assumes writes are taken on the rising edge with the strobe high.
module vga_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Register port
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 100ps;
  int cyc = 0;
  int last_gain = -1000;
  initial
  begin
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h5a;
  end
  always @(posedge clk_sys_i) cyc <= cyc + 1;
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #2;
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge clk_sys_i);
    #2;
    reg_wr_o = 1'b0;
    // Released data shows the inverse, never a stale copy
    reg_wdata_o = ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    #2;
    reg_addr_o = a;
    @(posedge clk_sys_i);
    #2;
    d = reg_rdata_i;
  endtask
  // Gap sets how slowly the lower byte follows the upper one
  task automatic write_gain(input logic [15:0] w, input int gap);
    while (cyc - last_gain < vga_pkg::MIN_GAIN_UPDATE_CLKS) @(posedge clk_sys_i);
    write_reg(vga_pkg::ADDR_GAIN_UPPER, w[15:8]);
    repeat (gap) @(posedge clk_sys_i);
    write_reg(vga_pkg::ADDR_GAIN_LOWER, w[7:0]);
    last_gain = cyc;
  endtask
endmodule

// File: test/vga_gain_control_agc_test.sv
// Bench for the gain control block: host model, register model, checker.
// Assumes the block's hand-over timing at a 40 MHz clock.
module vga_gain_control_agc_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic overload_indication_i = 1'b0;
  logic adc_reset_event_i = 1'b0;
  logic report_enable_i = 1'b0;
  logic signed [15:0] sample_i = 16'sh0000;
  logic reg_wr_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, gain_dac_code_o;
  logic [7:0] report_gain_o, report_overload_cnt_o, report_reset_cnt_o;
  logic dac_low_res_o, preamp_attenuate_bit_o, auto_mode_o, report_valid_o;
  logic [31:0] lfsr = 32'he2954fd9;
  logic [31:0] smp_lfsr = 32'he2954fd9;
  bit smp_on = 1'b1;
  bit smp_sq = 1'b0;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int mdl [0:7] = '{0, 0, 0, 'h3f, 'hff, 0, 0, 0};
  int gq [$];
  int snap, a0, a1, b0, b1;
  logic [15:0] w;

  vga_host_model host_u (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
  vga_gain_ctrl dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .sample_i(sample_i), .overload_indication_i(overload_indication_i),
    .adc_reset_event_i(adc_reset_event_i), .report_enable_i(report_enable_i),
    .gain_dac_code_o(gain_dac_code_o), .dac_low_res_o(dac_low_res_o),
    .preamp_attenuate_bit_o(preamp_attenuate_bit_o), .auto_mode_o(auto_mode_o),
    .report_valid_o(report_valid_o), .report_gain_o(report_gain_o),
    .report_overload_cnt_o(report_overload_cnt_o), .report_reset_cnt_o(report_reset_cnt_o));

  initial forever #12.5 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] rnd8();
    lfsr = next_rand(lfsr);
    return lfsr[7:0];
  endfunction
  function automatic logic [7:0] man_code();
    return 8'((mdl[3] << 1) | (mdl[4] >> 7));
  endfunction

  always @(posedge clk_sys_i)
  begin
    #2;
    smp_lfsr = next_rand(smp_lfsr);
    // Square tone at an eighth of the clock lands on the mix frequency
    sample_i = smp_sq ? (cycles[2] ? -16'sd32767 : 16'sd32767) :
               smp_on ? $signed(smp_lfsr[15:0]) : 16'sh0000;
  end
  // Whole run needs about 20000 clocks
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.write_reg(a, d);
    if (a >= 8'h03 && a <= 8'h06) mdl[a] = d;
  endtask
  // Unmapped places 2 and 7 read as zero
  task automatic chk_regs();
    logic [7:0] d;
    for (int a = 2; a < 8; a++)
    begin
      host_u.read_reg(8'(a), d);
      cmp("register", 8'(mdl[a]), d);
    end
  endtask
  task automatic pulse(input bit ovl);
    if (ovl) overload_indication_i = 1'b1;
    else adc_reset_event_i = 1'b1;
    tick(4);
    overload_indication_i = 1'b0;
    adc_reset_event_i = 1'b0;
    tick(4);
  endtask
  task automatic wait_report();
    int n = 0;
    do
    begin
      tick(1);
      n++;
    end while (report_valid_o !== 1'b1 && n < 1300);
    cmp("report valid", 8'h01, {7'h00, report_valid_o});
  endtask

  initial
  begin
    tick(8);
    resetn_i = 1'b1;
    cmp("reset code", 8'h7f, gain_dac_code_o);
    chk_regs();
    wr(vga_pkg::ADDR_ATTACK_DECAY, rnd8());
    wr(8'h07, rnd8());
    wr(vga_pkg::ADDR_OVL_FAST_REF, (rnd8() & 8'hf0) | 8'h08);
    chk_regs();
    cmp("fast on", 8'h01, {7'h00, dac_low_res_o});
    for (int k = 0; k < 3; k++)
    begin
      w = (k == 0) ? 16'h8000 : (k == 1) ? 16'h7fff : {rnd8(), rnd8()};
      fork
        host_u.write_gain(w, 30);
        begin
          @(posedge clk_sys_i iff (reg_wr_i && reg_addr_i == vga_pkg::ADDR_GAIN_UPPER));
          tick(25);
          cmp("half word", man_code(), gain_dac_code_o);
        end
      join
      mdl[3] = w[15:8];
      mdl[4] = w[7:0];
      gq.push_back(w);
      tick(30);
      cmp("manual code", man_code(), gain_dac_code_o);
      cmp("attenuate", {7'h00, gq[k][15]}, {7'h00, preamp_attenuate_bit_o});
    end
    chk_regs();
    report_enable_i = 1'b1;
    wait_report();
    for (int k = 0; k < 5; k++) pulse(k > 2);
    wait_report();
    cmp("overload count", 8'h02, report_overload_cnt_o);
    cmp("reset count", 8'h03, report_reset_cnt_o);
    cmp("report gain", man_code(), report_gain_o);
    for (int r = 0; r < 8; r++)
    begin
      wr(vga_pkg::ADDR_OVL_FAST_REF, 8'hf0 | 8'(r));
      tick(3);
      cmp("auto mode", {7'h00, r != 0}, {7'h00, auto_mode_o});
      cmp("fast off", 8'h00, {7'h00, dac_low_res_o});
    end
    wr(vga_pkg::ADDR_OVL_FAST_REF, 8'hf1);
    wr(vga_pkg::ADDR_ATTACK_DECAY, 8'hf0);
    tick(80);
    snap = gain_dac_code_o;
    overload_indication_i = 1'b1;
    tick(45);
    overload_indication_i = 1'b0;
    snap = (snap >= 'h40) ? snap - 'h40 : 0;
    cmp("overload cut", 8'h01, {7'h00, gain_dac_code_o <= 8'(snap)});
    // Zero input keeps the estimate under the reference
    smp_on = 1'b0;
    tick(60);
    a0 = gain_dac_code_o;
    tick(4000);
    a1 = gain_dac_code_o;
    cmp("recovery", 8'h01, {7'h00, a1 > a0});
    wr(vga_pkg::ADDR_ATTACK_DECAY, 8'hff);
    b0 = gain_dac_code_o;
    tick(4000);
    b1 = gain_dac_code_o;
    cmp("slow recovery", 8'h01, {7'h00, (b1 - b0) < (a1 - a0)});
    // Full-scale tone sits above level five, so the loop must pull gain down
    smp_sq = 1'b1;
    wr(vga_pkg::ADDR_OVL_FAST_REF, 8'hf5);
    tick(120);
    b0 = gain_dac_code_o;
    tick(9000);
    cmp("attack", 8'h01, {7'h00, gain_dac_code_o < 8'(b0)});
    smp_sq = 1'b0;
    smp_on = 1'b1;
    wr(vga_pkg::ADDR_OVL_FAST_REF, 8'h00);
    tick(40);
    cmp("back to manual", man_code(), gain_dac_code_o);
    chk_regs();
    finish_test();
  end
endmodule

bind vga_gain_ctrl vga_gain_props props_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .overload_indication_i(overload_indication_i), .report_enable_i(report_enable_i),
  .gain_dac_code_o(gain_dac_code_o), .dac_low_res_o(dac_low_res_o),
  .preamp_attenuate_bit_o(preamp_attenuate_bit_o), .auto_mode_o(auto_mode_o),
  .report_valid_o(report_valid_o), .report_gain_o(report_gain_o));
